// [src/jnpp_pkg.sv]
/*
 * Package for the JTAG programming port: opcodes, register widths,
 * unlock signature, reset values and timing constants.
 * Assumes a 20 MHz system clock and a TCK domain driven by the programmer.
 */
package jnpp_pkg;
    localparam int IR_W = 4;
    localparam logic [3:0] OP_UNLOCK = 4'h4;
    localparam logic [3:0] OP_COMMAND = 4'h5;
    localparam logic [3:0] OP_FILL = 4'h6;
    localparam logic [3:0] OP_READ = 4'h7;
    localparam logic [3:0] OP_RESET = 4'hc;
    localparam logic [3:0] OP_BYPASS = 4'hf;
    localparam int UNLOCK_W = 16;
    localparam logic [15:0] UNLOCK_SIG = 16'ha370;
    localparam logic [15:0] UNLOCK_RST = 16'h0000;
    localparam int CMD_W = 15;
    localparam logic [14:0] CMD_RST = 15'h0000;
    localparam int BYTE_W = 8;
    localparam int FILL_LIMIT_TCK = 11;
    // Result bit that carries the busy/done flag in the returned word
    localparam int DONE_BIT = 9;
    // Start-up time-out after the reset register drops, in microseconds
    localparam int STARTUP_US = 65;
    localparam int CLOCK_MHZ = 20;
    localparam int STARTUP_CYC = STARTUP_US * CLOCK_MHZ;
    localparam int STARTUP_CW = 12;

    typedef enum logic [3:0] {
        JNPP_RESET, JNPP_IDLE, JNPP_SEL_DR, JNPP_CAP_DR, JNPP_SHIFT_DR,
        JNPP_EXIT1_DR, JNPP_PAUSE_DR, JNPP_EXIT2_DR, JNPP_UPD_DR,
        JNPP_SEL_IR, JNPP_CAP_IR, JNPP_SHIFT_IR, JNPP_EXIT1_IR,
        JNPP_PAUSE_IR, JNPP_EXIT2_IR, JNPP_UPD_IR
    } jnpp_tap_t;
endpackage

// [src/jnpp_port.sv]
/*
 * JTAG programming port: TAP, unlock, command, page fill/read and reset
 * data registers, with the NVM programming interface on the system clock.
 * Assumes TCK from the programmer; the memory answers on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [R1] Opcode 0x4 selects the 16-bit unlock register, shifted during Shift-DR.
// [R2] Update-DR compares unlock register with 0xA370; equal enters programming mode.
// [R3] Unlock register clears at reset; programmer clears it on leaving.
// [R4] Opcode 0x5 selects the 15-bit command register.
// [R5] Capture-DR under commands loads the previous command result.
// [R6] Update-DR applies command; each Run-Test/Idle gives one execute clock.
// [R7] Opcode 0x6 selects the 8-bit byte register, low command bits.
// [R8] Page-fill Update-DR copies byte to holding register, written within 11 TCK.
// [R9] Page-fill updates alternate low/high byte, starting low.
// [R10] Fill increments address before each low byte except the first.
// [R11] Opcode 0x7 captures addressed memory byte on each Capture-DR.
// [R12] Page-read captures alternate low/high byte, starting low.
// [R13] Read increments address after every high-byte capture.
// [R14] Reset register one holds the device in reset, unlatched.
// [R15] After reset register clears, device stays reset for start-up time-out.
// [R16] Programmer resets the device before entering programming mode.
// [R17] Chip erase command sequence then completion polling via result word.
// [R18] Flash write: enter, address bytes, data bytes, latch sequence.
// [R19] Page commit: three command words trigger the flash page write.
// [R20] Page write pending polled; one flag bit reports completion.
// [R21] Flash read: enter, address, three words return low then high byte.
// [R22] EEPROM write, commit and polling command words.
// [R23] All shift registers shift least significant bit first.
// [R24] Instruction register is four bits wide.
// [R25] Programmer may omit setup word if upper seven bits already set.
module jnpp_port
    import jnpp_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    // System clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // JTAG pins
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    // NVM programming interface (system clock)
    output logic PROG_MODE,
    output logic [14:0] NVM_CMD,
    output logic NVM_EXEC,
    input wire logic [14:0] NVM_RESULT,
    output logic FILL_WRITE,
    output logic FILL_HIGH,
    output logic [7:0] FILL_DATA,
    output logic READ_STROBE,
    output logic READ_HIGH,
    input wire logic [7:0] READ_DATA,
    output logic ADDR_INC,
    // Device reset
    output logic DEVICE_RESET
);

    // TCK domain
    jnpp_tap_t tap;
    jnpp_tap_t next_tap;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir;
    logic [UNLOCK_W-1:0] unlock_sr;
    logic [CMD_W-1:0] cmd_sr;
    logic rst_sr;
    logic bypass_sr;
    logic unlocked_t;
    logic [CMD_W-1:0] cmd_t;
    logic cmd_tog;
    logic exec_tog;
    logic fill_tog;
    logic fill_phase;
    logic fill_first;
    logic [7:0] fill_hold;
    logic read_phase;
    logic read_tog;
    logic tdo_t;
    logic tdo_oe_t;
    logic [7:0] rdata_t1;
    logic [7:0] rdata_t2;
    logic [CMD_W-1:0] res_t1;
    logic [CMD_W-1:0] res_t2;
    logic fill_step;
    logic idle_seen;
    // System clock side, declared here because the TCK side reads nvm_result_s and rdata_s
    logic [14:0] nvm_result_s;
    logic [7:0] rdata_s;
    logic [2:0] cmd_sync;
    logic [3:0] exec_sync;
    logic [2:0] fill_sync;
    logic [2:0] read_sync;
    logic [1:0] unl_sync;
    logic [1:0] rst_sync;
    logic [STARTUP_CW-1:0] startup_cnt;

    always_comb begin
        next_tap = tap;
        case (tap)
            JNPP_RESET: next_tap = TMS ? JNPP_RESET : JNPP_IDLE;
            JNPP_IDLE: next_tap = TMS ? JNPP_SEL_DR : JNPP_IDLE;
            JNPP_SEL_DR: next_tap = TMS ? JNPP_SEL_IR : JNPP_CAP_DR;
            JNPP_CAP_DR: next_tap = TMS ? JNPP_EXIT1_DR : JNPP_SHIFT_DR;
            JNPP_SHIFT_DR: next_tap = TMS ? JNPP_EXIT1_DR : JNPP_SHIFT_DR;
            JNPP_EXIT1_DR: next_tap = TMS ? JNPP_UPD_DR : JNPP_PAUSE_DR;
            JNPP_PAUSE_DR: next_tap = TMS ? JNPP_EXIT2_DR : JNPP_PAUSE_DR;
            JNPP_EXIT2_DR: next_tap = TMS ? JNPP_UPD_DR : JNPP_SHIFT_DR;
            JNPP_UPD_DR: next_tap = TMS ? JNPP_SEL_DR : JNPP_IDLE;
            JNPP_SEL_IR: next_tap = TMS ? JNPP_RESET : JNPP_CAP_IR;
            JNPP_CAP_IR: next_tap = TMS ? JNPP_EXIT1_IR : JNPP_SHIFT_IR;
            JNPP_SHIFT_IR: next_tap = TMS ? JNPP_EXIT1_IR : JNPP_SHIFT_IR;
            JNPP_EXIT1_IR: next_tap = TMS ? JNPP_UPD_IR : JNPP_PAUSE_IR;
            JNPP_PAUSE_IR: next_tap = TMS ? JNPP_EXIT2_IR : JNPP_PAUSE_IR;
            JNPP_EXIT2_IR: next_tap = TMS ? JNPP_UPD_IR : JNPP_SHIFT_IR;
            JNPP_UPD_IR: next_tap = TMS ? JNPP_SEL_DR : JNPP_IDLE;
            default: next_tap = JNPP_RESET;
        endcase
    end

    // TAP reset comes from Test-Logic-Reset only; the chip reset never touches it
    always_ff @(posedge TCK) begin
        tap <= next_tap;
    end

    // [R24] Four-bit instruction register
    always_ff @(posedge TCK) begin
        if (tap == JNPP_RESET) begin
            ir <= OP_BYPASS;
            ir_shift <= '0;
        end else if (tap == JNPP_CAP_IR) begin
            ir_shift <= 4'h1;
        end else if (tap == JNPP_SHIFT_IR) begin
            // [R23] LSB first
            ir_shift <= {TDI, ir_shift[IR_W-1:1]};
        end else if (tap == JNPP_UPD_IR) begin
            ir <= ir_shift;
        end
    end

    // Memory answers resynchronised into TCK
    always_ff @(posedge TCK) begin
        rdata_t1 <= rdata_s;
        rdata_t2 <= rdata_t1;
        res_t1 <= nvm_result_s;
        res_t2 <= res_t1;
    end

    // [R1] Unlock register shift and [R2] compare on update
    always_ff @(posedge TCK) begin
        if (tap == JNPP_RESET) begin
            // [R3] Cleared at reset
            unlock_sr <= UNLOCK_RST;
            unlocked_t <= 1'b0;
        end else if (ir == OP_UNLOCK && tap == JNPP_SHIFT_DR) begin
            unlock_sr <= {TDI, unlock_sr[UNLOCK_W-1:1]};
        end else if (ir == OP_UNLOCK && tap == JNPP_UPD_DR) begin
            unlocked_t <= (unlock_sr == UNLOCK_SIG);
        end
    end

    // Command register; the byte register is its low eight bits
    always_ff @(posedge TCK) begin
        if (tap == JNPP_RESET) begin
            cmd_sr <= CMD_RST;
        end else if (tap == JNPP_CAP_DR) begin
            // [R5] Capture previous result
            if (ir == OP_COMMAND) begin
                cmd_sr <= res_t2;
            end else if (ir == OP_READ) begin
                // [R11] Capture addressed byte
                cmd_sr[BYTE_W-1:0] <= rdata_t2;
            end
        end else if (tap == JNPP_SHIFT_DR) begin
            // [R4] Fifteen-bit path, [R23] LSB first
            if (ir == OP_COMMAND) begin
                cmd_sr <= {TDI, cmd_sr[CMD_W-1:1]};
            end else if (ir == OP_FILL || ir == OP_READ) begin
                // [R7] Eight-bit path
                cmd_sr[BYTE_W-1:0] <= {TDI, cmd_sr[BYTE_W-1:1]};
            end
        end
    end

    // [R17] [R18] [R19] [R20] [R21] [R22] Command words applied
    // [R6] Apply on update, one execute per idle visit
    always_ff @(posedge TCK) begin
        idle_seen <= (tap == JNPP_IDLE);
        if (tap == JNPP_RESET) begin
            cmd_t <= CMD_RST;
            cmd_tog <= 1'b0;
            exec_tog <= 1'b0;
        end else if (ir == OP_COMMAND && tap == JNPP_UPD_DR) begin
            cmd_t <= cmd_sr;
            cmd_tog <= ~cmd_tog;
        end else if (ir == OP_COMMAND && unlocked_t && tap == JNPP_IDLE && !idle_seen) begin
            exec_tog <= ~exec_tog;
        end
    end

    // [R8] Holding register, [R9] low/high alternation, [R10] address step
    always_ff @(posedge TCK) begin
        if (tap == JNPP_RESET || tap == JNPP_UPD_IR) begin
            fill_phase <= 1'b0;
            fill_first <= 1'b1;
            fill_step <= 1'b0;
            fill_tog <= 1'b0;
            fill_hold <= '0;
        end else if (ir == OP_FILL && tap == JNPP_UPD_DR) begin
            fill_hold <= cmd_sr[BYTE_W-1:0];
            // Low byte after the first one steps the address
            fill_step <= ~fill_phase && ~fill_first;
            fill_phase <= ~fill_phase;
            fill_first <= 1'b0;
            fill_tog <= ~fill_tog;
        end
    end

    // [R12] Read alternation, [R13] post-increment after high
    always_ff @(posedge TCK) begin
        if (tap == JNPP_RESET || tap == JNPP_UPD_IR) begin
            read_phase <= 1'b0;
            read_tog <= 1'b0;
        end else if (ir == OP_READ && tap == JNPP_CAP_DR) begin
            read_phase <= ~read_phase;
            read_tog <= ~read_tog;
        end
    end

    // [R14] Reset register, shifted and held as an unlatched level
    always_ff @(posedge TCK) begin
        // Cleared in Test-Logic-Reset so power-up leaves the device running
        if (tap == JNPP_RESET) begin
            rst_sr <= 1'b0;
        end else if (ir == OP_RESET && tap == JNPP_SHIFT_DR) begin
            rst_sr <= TDI;
        end
        if (tap == JNPP_SHIFT_DR) begin
            bypass_sr <= TDI;
        end
    end

    // TDO changes on the falling edge, per TAP practice
    always_ff @(negedge TCK) begin
        tdo_oe_t <= (tap == JNPP_SHIFT_DR) || (tap == JNPP_SHIFT_IR);
        if (tap == JNPP_SHIFT_IR) begin
            tdo_t <= ir_shift[0];
        end else if (ir == OP_UNLOCK) begin
            tdo_t <= unlock_sr[0];
        end else if (ir == OP_COMMAND || ir == OP_FILL || ir == OP_READ) begin
            tdo_t <= cmd_sr[0];
        end else if (ir == OP_RESET) begin
            tdo_t <= rst_sr;
        end else begin
            tdo_t <= bypass_sr;
        end
    end

    assign TDO = tdo_t;
    assign TDO_OE = tdo_oe_t;

    // System clock domain
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cmd_sync <= '0;
            exec_sync <= '0;
            fill_sync <= '0;
            read_sync <= '0;
            unl_sync <= '0;
            rst_sync <= '0;
        end else begin
            cmd_sync <= {cmd_sync[1:0], cmd_tog};
            // One stage more than the command path, so NVM_CMD settles first
            exec_sync <= {exec_sync[2:0], exec_tog};
            fill_sync <= {fill_sync[1:0], fill_tog};
            read_sync <= {read_sync[1:0], read_tog};
            unl_sync <= {unl_sync[0], unlocked_t};
            rst_sync <= {rst_sync[0], rst_sr};
        end
    end

    always_ff @(posedge CLOCK) begin
        nvm_result_s <= NVM_RESULT;
        rdata_s <= READ_DATA;
    end

    // Words held stable in TCK well before their toggle arrives
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            NVM_CMD <= CMD_RST;
            PROG_MODE <= 1'b0;
        end else begin
            PROG_MODE <= unl_sync[1];
            if (cmd_sync[2] != cmd_sync[1]) begin
                NVM_CMD <= cmd_t;
            end
        end
    end

    // [R8] Byte delivered within a few system clocks, well inside 11 TCK
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            NVM_EXEC <= 1'b0;
            FILL_WRITE <= 1'b0;
            FILL_HIGH <= 1'b0;
            FILL_DATA <= '0;
            READ_STROBE <= 1'b0;
            READ_HIGH <= 1'b0;
            ADDR_INC <= 1'b0;
        end else begin
            NVM_EXEC <= unl_sync[1] && (exec_sync[3] != exec_sync[2]);
            FILL_WRITE <= unl_sync[1] && (fill_sync[2] != fill_sync[1]);
            READ_STROBE <= unl_sync[1] && (read_sync[2] != read_sync[1]);
            // TCK words taken only at their event, while they stand still
            if (fill_sync[2] != fill_sync[1]) begin
                // Phase already toggled: a set phase means this byte was low
                FILL_HIGH <= ~fill_phase;
                FILL_DATA <= fill_hold;
            end
            if (read_sync[2] != read_sync[1]) begin
                READ_HIGH <= ~read_phase;
            end
            // [R10] Pre-increment before non-first low; [R13] post after high
            ADDR_INC <= unl_sync[1] && (((fill_sync[2] != fill_sync[1]) && fill_step)
                || ((read_sync[2] != read_sync[1]) && !read_phase));
        end
    end

    // [R14] Held in reset while register set, [R15] then start-up time-out
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            startup_cnt <= '0;
            DEVICE_RESET <= 1'b0;
        end else if (rst_sync[1]) begin
            startup_cnt <= STARTUP_CW'(STARTUP_CYCLES);
            DEVICE_RESET <= 1'b1;
        end else if (startup_cnt != '0) begin
            startup_cnt <= startup_cnt - 1'b1;
            DEVICE_RESET <= 1'b1;
        end else begin
            DEVICE_RESET <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [tb/jnpp_checker.sv]
/* Checker for the programming port: pulse shape, mode gating, reset hold.
   Assumes binding to jnpp_port; all checks on CLOCK. */
`timescale 1ns/100ps
`default_nettype none
module jnpp_checker #(
    parameter int STARTUP_CYCLES = 10
) (
    // System clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Watched outputs
    input wire logic PROG_MODE,
    input wire logic [14:0] NVM_CMD,
    input wire logic NVM_EXEC,
    input wire logic FILL_WRITE,
    input wire logic READ_STROBE,
    input wire logic ADDR_INC,
    input wire logic DEVICE_RESET
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    int high_cnt;
    // Cycles spent in device reset
    always_ff @(posedge CLOCK) begin
        if (RST || !DEVICE_RESET) begin
            high_cnt <= 0;
        end else begin
            high_cnt <= high_cnt + 1;
        end
    end
    sequence s_drop(logic sig);
        sig ##1 !sig;
    endsequence
    property p_pulse(logic sig);
        $rose(sig) |-> s_drop(sig);
    endproperty
    a_exec_gated: assert property (NVM_EXEC |-> PROG_MODE)
        else $error("execute pulse while locked");
    a_fill_gated: assert property (FILL_WRITE |-> PROG_MODE)
        else $error("fill write while locked");
    a_read_gated: assert property (READ_STROBE |-> PROG_MODE)
        else $error("read strobe while locked");
    a_exec_single: assert property (p_pulse(NVM_EXEC))
        else $error("execute pulse too long");
    a_fill_single: assert property (p_pulse(FILL_WRITE))
        else $error("fill write too long");
    a_inc_single: assert property (p_pulse(ADDR_INC))
        else $error("address step too long");
    a_cmd_held: assert property (NVM_EXEC |-> $stable(NVM_CMD))
        else $error("command moved during execute");
    a_startup_hold: assert property ($fell(DEVICE_RESET) |-> high_cnt >= STARTUP_CYCLES)
        else $error("device reset released early");
    a_fill_read_apart: assert property (!(FILL_WRITE && READ_STROBE))
        else $error("fill and read together");
endmodule
bind jnpp_port jnpp_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (
    .CLOCK(CLOCK), .RST(RST), .PROG_MODE(PROG_MODE), .NVM_CMD(NVM_CMD),
    .NVM_EXEC(NVM_EXEC), .FILL_WRITE(FILL_WRITE), .READ_STROBE(READ_STROBE),
    .ADDR_INC(ADDR_INC), .DEVICE_RESET(DEVICE_RESET)
);
`default_nettype wire

// [tb/jnpp_prog.sv]
/* JTAG programmer model: drives TCK, TMS, TDI and samples TDO.
   Assumes a standard TAP; TCK stands low between frames. */
`timescale 1ns/100ps
`default_nettype none
module jnpp_prog (
    // JTAG pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #24;
        q = tdo;
        tck = 1'b1;
        #24;
        tck = 1'b0;
    endtask
    task automatic tap_reset();
        logic q;
        repeat (5) pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
    endtask
    task automatic scan(input logic ir, input int n, input logic [15:0] v,
                        output logic [15:0] r);
        logic q;
        pulse(1'b1, 1'b0, q);
        if (ir) pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        r = '0;
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, v[i], q);
            r[i] = q;
        end
        pulse(1'b1, ~v[n - 1], q);
        pulse(1'b0, ~v[n - 1], q);
        pulse(1'b0, ~v[n - 1], q);
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
/* Self-checking bench for the programming port.
   Assumes jnpp_port, the programmer model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import jnpp_pkg::*;
    localparam int SU = 10;
    // Setup words left out where the upper bits already stand
    localparam logic [14:0] CMDS [8] = '{15'h2380, 15'h3180, 15'h3380, 15'h2310,
                                         15'h7700, 15'h3500, 15'h2302, 15'h2311};
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic [14:0] nvm_result = '0;
    logic [7:0] read_data = '0;
    wire logic tck, tms, tdi, tdo, tdo_oe, tdo_pin, prog_mode, nvm_exec, fill_write;
    wire logic fill_high, read_strobe, read_high, addr_inc, device_reset;
    wire logic [14:0] nvm_cmd;
    wire logic [7:0] fill_data;
    int num_errors = 0;
    int total_checks = 0;
    int n_exec = 0;
    int n_inc = 0;
    int n_ev = 0;
    int cyc = 0;
    logic [15:0] ev [16];
    always #25 CLOCK = ~CLOCK;
    assign tdo_pin = tdo_oe ? tdo : ~tdo;
    jnpp_port #(.STARTUP_CYCLES(SU)) dut_u (.CLOCK(CLOCK), .RST(RST), .TCK(tck),
        .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .PROG_MODE(prog_mode),
        .NVM_CMD(nvm_cmd), .NVM_EXEC(nvm_exec), .NVM_RESULT(nvm_result),
        .FILL_WRITE(fill_write), .FILL_HIGH(fill_high), .FILL_DATA(fill_data),
        .READ_STROBE(read_strobe), .READ_HIGH(read_high), .READ_DATA(read_data),
        .ADDR_INC(addr_inc), .DEVICE_RESET(device_reset));
    jnpp_prog prog_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Pulse log: byte side, address steps seen, data
    always @(posedge CLOCK) begin
        if (nvm_exec === 1'b1) n_exec++;
        if (fill_write === 1'b1 || read_strobe === 1'b1) begin
            ev[n_ev % 16] = {fill_write ? fill_high : read_high,
                             7'(n_inc + int'(fill_write && addr_inc)), fill_data};
            n_ev++;
        end
        if (addr_inc === 1'b1) n_inc++;
        cyc++;
        if (cyc > 8000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string s);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLOCK);
        #2;
    endtask
    task automatic t_reset_reg(input logic v);
        logic [15:0] r;
        prog_u.scan(1'b1, IR_W, 16'(OP_RESET), r);
        prog_u.scan(1'b0, 1, 16'(v), r);
        wait_clk(5);
        check(16'(device_reset), 16'h0001, "reset held");
        if (!v) begin
            wait_clk(SU + 8);
            check(16'(device_reset), 16'h0000, "reset released");
        end
    endtask
    task automatic t_unlock();
        logic [15:0] r;
        int e;
        check(16'(prog_mode), 16'h0000, "mode after reset");
        e = n_exec;
        prog_u.scan(1'b1, IR_W, 16'(OP_COMMAND), r);
        prog_u.scan(1'b0, CMD_W, 16'h2380, r);
        wait_clk(8);
        check(16'(n_exec - e), 16'h0000, "locked exec");
        prog_u.scan(1'b1, IR_W, 16'(OP_UNLOCK), r);
        prog_u.scan(1'b0, UNLOCK_W, 16'h2370, r);
        wait_clk(8);
        check(16'(prog_mode), 16'h0000, "bad signature");
        prog_u.scan(1'b0, UNLOCK_W, 16'ha370, r);
        wait_clk(8);
        check(16'(prog_mode), 16'h0001, "good signature");
    endtask
    task automatic t_commands();
        logic [15:0] r;
        int e;
        prog_u.scan(1'b1, IR_W, 16'(OP_COMMAND), r);
        // Entering Idle executes the held word once; let that pulse pass
        wait_clk(8);
        for (int k = 0; k < 8; k++) begin
            wait_clk(1);
            nvm_result = ~CMDS[k];
            wait_clk(3);
            e = n_exec;
            prog_u.scan(1'b0, CMD_W, {1'b0, CMDS[k]}, r);
            wait_clk(6);
            check({1'b0, nvm_cmd}, {1'b0, CMDS[k]}, "command");
            check(r, {1'b0, ~CMDS[k]}, "result");
            check(16'(n_exec - e), 16'h0001, "exec count");
        end
    endtask
    task automatic t_fill();
        logic [15:0] r;
        int n0;
        int i0;
        prog_u.scan(1'b1, IR_W, 16'(OP_FILL), r);
        n0 = n_ev;
        i0 = n_inc;
        for (int k = 0; k < 4; k++) begin
            prog_u.scan(1'b0, BYTE_W, 16'(17 * (k + 1)), r);
            wait_clk(6);
            check(16'(n_ev - n0), 16'(k + 1), "byte written");
            check(ev[(n0 + k) % 16], {1'(k), 7'(i0 + k / 2), 8'(17 * (k + 1))}, "fill");
        end
        check(16'(n_inc - i0), 16'h0001, "fill steps");
    endtask
    task automatic t_read();
        logic [15:0] r;
        int n0;
        int i0;
        prog_u.scan(1'b1, IR_W, 16'(OP_READ), r);
        n0 = n_ev;
        i0 = n_inc;
        for (int k = 0; k < 4; k++) begin
            wait_clk(1);
            read_data = 8'(8'h3c + 8'h21 * k);
            wait_clk(3);
            prog_u.scan(1'b0, BYTE_W, 16'h0000, r);
            wait_clk(6);
            check(r, 16'(8'(8'h3c + 8'h21 * k)), "read byte");
            check({ev[(n0 + k) % 16][15:8], 8'h00}, {1'(k), 7'(i0 + k / 2), 8'h00}, "read");
        end
        check(16'(n_inc - i0), 16'h0002, "read steps");
    endtask
    initial begin
        // TAP settles while the system side is still held in reset
        fork
            prog_u.tap_reset();
        join_none
        repeat (12) @(posedge CLOCK);
        #2;
        RST = 1'b0;
        t_reset_reg(1'b1);
        t_unlock();
        t_commands();
        t_fill();
        t_read();
        t_reset_reg(1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
